// ==== design/rio_seq_pkg.sv ====
package rio_seq_pkg;
    localparam int NCH = 8;
    localparam int CHW = 3;
    localparam int NIF = 3;
    localparam logic [15:0] CMD_IDLE = 16'h0000;
    localparam logic [15:0] CMD_HALT = 16'h0800;
    localparam int CMD_IGNORE_BIT = 15;
    localparam int CMD_OP_MSB = 14;
    localparam int CMD_OP_LSB = 8;
    localparam int CMD_MASK_MSB = 7;
    localparam logic [6:0] OP_HALT = 7'h08;
    localparam logic [6:0] OP_START = 7'h09;
    localparam logic [6:0] OP_SETUP = 7'h0F;
    localparam logic [6:0] OP_XFER = 7'h10;
    localparam int CS_OP_MSB = 31;
    localparam int CS_OP_LSB = 24;
    localparam logic [7:0] RD_FIRST = 8'h44;
    localparam logic [7:0] RD_LAST = 8'h47;
    localparam logic [7:0] WR_FIRST = 8'h64;
    localparam logic [7:0] WR_LAST = 8'h67;
    localparam int TOC_IF = 2;
    localparam logic [2:0] SEL_CMD = 3'h0;
    localparam logic [2:0] SEL_DATA = 3'h1;
    localparam logic [2:0] SEL_CS = 3'h2;
    localparam logic [2:0] SEL_IF0 = 3'h3;
    localparam logic [2:0] SEL_IF1 = 3'h4;
    localparam logic [2:0] SEL_IF2 = 3'h5;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam int CLK_PERIOD_NS = 5;
    localparam int XFER_TIME_NS = 100_000;
    localparam int START_TIME_NS = 50_000_000;
    localparam int XFER_CYCLES = XFER_TIME_NS / CLK_PERIOD_NS;
    localparam int START_CYCLES = START_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_e;
    typedef enum logic [1:0] {MODE_IDLE, MODE_CYCLIC, MODE_SETUP} chmode_e;
    typedef enum logic [1:0] {REQ_HALT, REQ_START, REQ_SETUP, REQ_XFER} req_e;

    typedef struct packed {
        req_e kind;
        logic [CHW-1:0] chan;
        logic [31:0] cs;
        logic [NIF-1:0][31:0] ifr;
    } req_s;

    typedef struct packed {
        logic [CHW-1:0] chan;
        logic fail;
        logic [31:0] cs;
        logic [NIF-1:0][31:0] ifr;
    } resp_s;

    typedef struct packed {
        seq_e seq;
        logic [15:0] cmd;
        logic [NCH-1:0] mask;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] dataReg;
        req_e kind;
        logic [CHW:0] idx;
        logic [31:0] timer;
        chmode_e [NCH-1:0] mode;
        logic [NCH-1:0][31:0] csOut;
        logic [NCH-1:0][31:0] csIn;
        logic [NCH-1:0][NIF-1:0][31:0] ifOut;
        logic [NCH-1:0][NIF-1:0][31:0] ifIn;
        logic reqValid;
        req_s req;
        resp_s [1:0] buffer;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic respReady;
        logic [31:0] rdata;
        logic busy;
    } st_s;

    localparam st_s ST_RESET = '0;
endpackage : rio_seq_pkg

// ==== design/remote_io_channel_sequencer.sv ====
// Function
// - halt command stops all channels, then clears
// - normal start runs cyclic on masked channels
// - setup start opens pass-through on masked channels
// - command clears when start completes
// - failed start sets channel data bit
// - failed transfer sets channel data bit
// - transfer trigger exchanges once per masked channel that is cyclic, or pass-through with a valid opcode
// - transfer completes within 100 microseconds
// - halt idles channels; setup start resets status
// - read opcode in control word top byte
// - width opcodes consecutive for reads and writes
// - setup transfer: zero data on success
// - table pointer appears in interface register 2
// - default data sits in interface register 0
// - status bytes returned in control word
// - elements packed LSB first, register 0 up
module remote_io_channel_sequencer
    import rio_seq_pkg::*;
#(
    parameter int unsigned XferCycles = XFER_CYCLES,
    parameter int unsigned StartCycles = START_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hostWr,
    input wire logic [2:0] hostSel,
    input wire logic [CHW-1:0] hostChan,
    input wire logic [31:0] hostWData,
    output logic [31:0] hostRData,
    output logic cmdBusy,
    output logic reqValid,
    output req_s reqData,
    input wire logic reqReady,
    input wire logic respValid,
    input wire resp_s respData,
    output logic respReady
);
    st_s s_r;
    st_s s_nxt;
    logic cmdWr;
    logic haltWr;
    logic [6:0] op;
    logic push;
    logic pop;
    resp_s head;
    logic [CHW-1:0] ch;
    logic [7:0] csOp;
    logic okOp;
    logic localFail;
    logic [31:0] limit;

    assign cmdWr = hostWr && hostSel == SEL_CMD && !hostWData[CMD_IGNORE_BIT];
    assign op = hostWData[CMD_OP_MSB:CMD_OP_LSB];
    assign haltWr = cmdWr && op == OP_HALT;

    always_comb begin
        s_nxt = s_r;
        head = s_r.buffer[s_r.rp];
        ch = s_r.idx[CHW-1:0];
        csOp = s_r.csOut[ch][CS_OP_MSB:CS_OP_LSB];
        // pass-through opcodes: reads and writes, byte to double
        okOp = (csOp >= RD_FIRST && csOp <= RD_LAST)
            || (csOp >= WR_FIRST && csOp <= WR_LAST);
        localFail = 1'b0;
        limit = (s_r.kind == REQ_XFER) ? XferCycles : StartCycles;
        push = respValid && s_r.respReady;
        // stale answers drain in idle; issuing stalls the buffer
        pop = s_r.cnt != 2'h0 && s_r.seq != S_ISSUE;
        if (hostWr) begin
            case (hostSel)
                SEL_CS: s_nxt.csOut[hostChan] = hostWData;
                SEL_IF0: s_nxt.ifOut[hostChan][0] = hostWData;
                SEL_IF1: s_nxt.ifOut[hostChan][1] = hostWData;
                SEL_IF2: s_nxt.ifOut[hostChan][2] = hostWData;
                default: ;
            endcase
        end
        case (hostSel)
            SEL_CMD: s_nxt.rdata = {16'h0000, s_r.cmd};
            SEL_DATA: s_nxt.rdata = {24'h000000, s_r.dataReg};
            SEL_CS: s_nxt.rdata = s_r.csIn[hostChan];
            SEL_IF0: s_nxt.rdata = s_r.ifIn[hostChan][0];
            SEL_IF1: s_nxt.rdata = s_r.ifIn[hostChan][1];
            SEL_IF2: s_nxt.rdata = s_r.ifIn[hostChan][TOC_IF];
            default: s_nxt.rdata = 32'h00000000;
        endcase
        if (push) begin
            s_nxt.buffer[s_r.wp] = respData;
            s_nxt.wp = ~s_r.wp;
        end
        if (pop) begin
            s_nxt.rp = ~s_r.rp;
        end
        case ({push, pop})
            2'b10: s_nxt.cnt = s_r.cnt + 2'h1;
            2'b01: s_nxt.cnt = s_r.cnt - 2'h1;
            default: s_nxt.cnt = s_r.cnt;
        endcase
        if (s_r.reqValid && reqReady) begin
            s_nxt.reqValid = 1'b0;
        end
        if (haltWr) begin
            // halt is honoured even while busy; a request not yet
            // taken is withdrawn
            s_nxt.cmd = CMD_HALT;
            s_nxt.kind = REQ_HALT;
            s_nxt.mask = '0;
            s_nxt.pend = '0;
            s_nxt.reqValid = 1'b0;
            s_nxt.timer = 32'h00000000;
            s_nxt.seq = S_WAIT;
            for (int i = 0; i < NCH; i++) begin
                s_nxt.mode[i] = MODE_IDLE;
            end
        end else begin
            case (s_r.seq)
                S_IDLE: begin
                    // busy register refuses anything but halt
                    if (cmdWr && s_r.cmd == CMD_IDLE
                        && (op == OP_START || op == OP_SETUP
                        || op == OP_XFER)) begin
                        s_nxt.cmd = hostWData[15:0];
                        s_nxt.mask = hostWData[CMD_MASK_MSB:0];
                        s_nxt.kind = (op == OP_START) ? REQ_START
                            : (op == OP_SETUP) ? REQ_SETUP : REQ_XFER;
                        s_nxt.dataReg = '0;
                        s_nxt.pend = '0;
                        s_nxt.idx = '0;
                        s_nxt.timer = 32'h00000000;
                        s_nxt.seq = S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    s_nxt.timer = s_r.timer + 32'h00000001;
                    if (s_r.idx < 4'(NCH)) begin
                        localFail = s_r.kind == REQ_XFER
                            && (s_r.mode[ch] == MODE_IDLE
                            || (s_r.mode[ch] == MODE_SETUP && !okOp));
                        if (!s_r.mask[ch]) begin
                            s_nxt.idx = s_r.idx + 4'h1;
                        end else if (localFail) begin
                            s_nxt.dataReg[ch] = 1'b1;
                            s_nxt.idx = s_r.idx + 4'h1;
                        end else if (!s_r.reqValid) begin
                            // one exchange per masked channel
                            s_nxt.req.kind = s_r.kind;
                            s_nxt.req.chan = ch;
                            s_nxt.req.cs = s_r.csOut[ch];
                            s_nxt.req.ifr = s_r.ifOut[ch];
                            s_nxt.reqValid = 1'b1;
                            s_nxt.pend[ch] = 1'b1;
                            s_nxt.idx = s_r.idx + 4'h1;
                            if (s_r.kind != REQ_XFER) begin
                                s_nxt.mode[ch] = MODE_IDLE;
                                s_nxt.csIn[ch] = 32'h00000000;
                                s_nxt.ifIn[ch] = '0;
                            end
                        end
                    end else if (!s_nxt.reqValid) begin
                        s_nxt.seq = S_WAIT;
                    end
                end
                S_WAIT: begin
                    s_nxt.timer = s_r.timer + 32'h00000001;
                    if (pop && s_r.pend[head.chan]) begin
                        s_nxt.pend[head.chan] = 1'b0;
                        s_nxt.dataReg[head.chan] = head.fail;
                        s_nxt.csIn[head.chan] = head.cs;
                        s_nxt.ifIn[head.chan] = head.ifr;
                        if (s_r.kind == REQ_START) begin
                            s_nxt.mode[head.chan] = head.fail
                                ? MODE_IDLE : MODE_CYCLIC;
                        end else if (s_r.kind == REQ_SETUP) begin
                            s_nxt.mode[head.chan] = head.fail
                                ? MODE_IDLE : MODE_SETUP;
                        end
                    end
                    if (s_nxt.pend == '0) begin
                        s_nxt.cmd = CMD_IDLE;
                        s_nxt.seq = S_IDLE;
                    end else if (s_r.timer >= limit) begin
                        // silent channels count as failed
                        s_nxt.dataReg = s_nxt.dataReg | s_nxt.pend;
                        s_nxt.pend = '0;
                        s_nxt.cmd = CMD_IDLE;
                        s_nxt.seq = S_IDLE;
                    end
                end
                default: s_nxt.seq = S_IDLE;
            endcase
        end
        s_nxt.respReady = s_nxt.cnt != BUF_FULL;
        s_nxt.busy = s_nxt.cmd != CMD_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hostRData = s_r.rdata;
    assign cmdBusy = s_r.busy;
    assign reqValid = s_r.reqValid;
    assign reqData = s_r.req;
    assign respReady = s_r.respReady;

    // assertion helpers
    logic [31:0] xferCnt;
    logic donePop;
    logic [CHW-1:0] headChan;
    assign donePop = pop && s_r.seq == S_WAIT && s_r.pend[head.chan]
        && !haltWr;
    assign headChan = head.chan;

    always_ff @(posedge clk) begin
        if (rst) begin
            xferCnt <= 32'h00000000;
        end else if (s_r.cmd[CMD_OP_MSB:CMD_OP_LSB] == OP_XFER) begin
            xferCnt <= xferCnt + 32'h00000001;
        end else begin
            xferCnt <= 32'h00000000;
        end
    end

    sequence s_haltIssued;
        haltWr;
    endsequence

    sequence s_haltSettles;
        (s_r.cmd == CMD_HALT) ##1 (s_r.cmd == CMD_IDLE);
    endsequence

    property p_haltClears;
        @(posedge clk) disable iff (rst)
        s_haltIssued ##1 !haltWr |-> s_haltSettles;
    endproperty
    a_haltClears: assert property (p_haltClears)
        else $error("halt did not clear command register");

    property p_haltIdles;
        @(posedge clk) disable iff (rst)
        s_haltIssued |=> (s_r.mode == '0) && !s_r.reqValid;
    endproperty
    a_haltIdles: assert property (p_haltIdles)
        else $error("halt left a channel active");

    property p_startCyclic;
        @(posedge clk) disable iff (rst)
        donePop && s_r.kind == REQ_START && !head.fail
            |=> s_r.mode[$past(headChan)] == MODE_CYCLIC;
    endproperty
    a_startCyclic: assert property (p_startCyclic)
        else $error("normal start did not enter cyclic mode");

    property p_setupPass;
        @(posedge clk) disable iff (rst)
        donePop && s_r.kind == REQ_SETUP && !head.fail
            |=> s_r.mode[$past(headChan)] == MODE_SETUP;
    endproperty
    a_setupPass: assert property (p_setupPass)
        else $error("setup start did not enter pass-through mode");

    property p_doneClears;
        @(posedge clk) disable iff (rst)
        s_r.seq == S_WAIT && s_r.pend == '0 && !haltWr
            |=> s_r.cmd == CMD_IDLE && s_r.seq == S_IDLE;
    endproperty
    a_doneClears: assert property (p_doneClears)
        else $error("command not cleared on completion");

    property p_failBit;
        @(posedge clk) disable iff (rst)
        donePop && head.fail |=> s_r.dataReg[$past(headChan)];
    endproperty
    a_failBit: assert property (p_failBit)
        else $error("failed channel not flagged");

    property p_okBit;
        @(posedge clk) disable iff (rst)
        donePop && !head.fail |=> !s_r.dataReg[$past(headChan)];
    endproperty
    a_okBit: assert property (p_okBit)
        else $error("successful channel flagged");

    property p_reqMasked;
        @(posedge clk) disable iff (rst)
        s_r.reqValid |-> s_r.cmd[s_r.req.chan] && s_r.pend[s_r.req.chan];
    endproperty
    a_reqMasked: assert property (p_reqMasked)
        else $error("request for an unmasked channel");

    property p_setupOp;
        @(posedge clk) disable iff (rst)
        s_r.reqValid && s_r.req.kind == REQ_XFER
            && s_r.mode[s_r.req.chan] == MODE_SETUP
            |-> (s_r.req.cs[CS_OP_MSB:CS_OP_LSB] inside
            {[RD_FIRST:RD_LAST], [WR_FIRST:WR_LAST]});
    endproperty
    a_setupOp: assert property (p_setupOp)
        else $error("pass-through request with bad opcode");

    property p_xferBound;
        @(posedge clk) disable iff (rst)
        xferCnt <= XferCycles + 32'd2;
    endproperty
    a_xferBound: assert property (p_xferBound)
        else $error("transfer exceeded its time bound");

    property p_statusStored;
        @(posedge clk) disable iff (rst)
        donePop |=> s_r.csIn[$past(headChan)] == $past(head.cs);
    endproperty
    a_statusStored: assert property (p_statusStored)
        else $error("status word not captured");

    property p_bufBound;
        @(posedge clk) disable iff (rst)
        s_r.cnt <= BUF_FULL;
    endproperty
    a_bufBound: assert property (p_bufBound)
        else $error("answer buffer overflowed");

    property p_busyFlag;
        @(posedge clk) disable iff (rst)
        s_r.busy == (s_r.cmd != CMD_IDLE);
    endproperty
    a_busyFlag: assert property (p_busyFlag)
        else $error("busy flag disagrees with command register");

    // idle channel cannot exchange, so it fails locally
    property p_idleFail;
        @(posedge clk) disable iff (rst)
        s_r.seq == S_ISSUE && s_r.idx < 4'(NCH) && s_r.kind == REQ_XFER
            && s_r.mask[ch] && s_r.mode[ch] == MODE_IDLE && !haltWr
            |=> s_r.dataReg[$past(ch)];
    endproperty
    a_idleFail: assert property (p_idleFail)
        else $error("transfer on idle channel not flagged");
endmodule : remote_io_channel_sequencer

// ==== verification/rio_remote_model.sv ====
module rio_remote_model
    import rio_seq_pkg::*;
#(
    parameter logic [31:0] TocPtr = 32'h0000_0100
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire req_s reqData,
    output logic reqReady,
    output logic respValid,
    output resp_s respData,
    input wire logic respReady,
    input wire logic [NCH-1:0] failMask,
    input wire logic [7:0] delay,
    input wire logic mute,
    output int nReq,
    output req_s lastReq
);
    timeunit 1ns;
    timeprecision 100ps;

    req_s q[$];
    int waitCnt;

    function automatic resp_s answer(req_s r);
        resp_s a;
        a.chan = r.chan;
        a.fail = failMask[r.chan];
        a.cs = 32'h1122_3344;
        a.ifr[2] = TocPtr;
        a.ifr[1] = r.ifr[1];
        a.ifr[0] = ~r.ifr[0];
        return a;
    endfunction : answer

    always @(posedge clk) begin
        if (rst) begin
            q.delete();
            nReq <= 0;
            lastReq <= '0;
            reqReady <= 1'b0;
            respValid <= 1'b0;
            respData <= '0;
            waitCnt <= 0;
        end else begin
            // slow mode takes a request only every other cycle
            reqReady <= (delay == 8'h00) || !reqReady;
            if (reqValid && reqReady) begin
                nReq <= nReq + 1;
                lastReq <= reqData;
                if (!mute) q.push_back(reqData);
            end
            if (respValid && !respReady) begin
                respValid <= 1'b1;
            end else if (q.size() > 0 && waitCnt >= int'(delay)) begin
                respValid <= 1'b1;
                respData <= answer(q.pop_front());
                waitCnt <= 0;
            end else begin
                respValid <= 1'b0;
                // released lines must not keep the last answer
                respData <= ~respData;
                waitCnt <= waitCnt + int'(q.size() > 0);
            end
        end
    end
endmodule : rio_remote_model

// ==== verification/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rio_seq_pkg::*;

    localparam int XC = 200;
    localparam int SC = 300;
    localparam logic [31:0] TOC = 32'h0000_0100;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hostWr = 1'b0;
    logic [2:0] hostSel = 3'h0;
    logic [CHW-1:0] hostChan = '0;
    logic [31:0] hostWData = 32'h0;
    logic [31:0] hostRData;
    logic cmdBusy, reqValid, reqReady, respValid, respReady;
    req_s reqData, lastReq;
    resp_s respData;
    logic [NCH-1:0] failMask = '0;
    logic [7:0] delay = 8'h00;
    logic mute = 1'b0;
    int nReq, base, stalls = 0;
    int mismatches = 0;
    int total_checks = 0;

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (!rst && respValid && !respReady) stalls <= stalls + 1;
    end

    remote_io_channel_sequencer #(.XferCycles(XC), .StartCycles(SC))
    i_remote_io_channel_sequencer (.clk(clk), .rst(rst), .hostWr(hostWr),
        .hostSel(hostSel), .hostChan(hostChan), .hostWData(hostWData),
        .hostRData(hostRData), .cmdBusy(cmdBusy), .reqValid(reqValid),
        .reqData(reqData), .reqReady(reqReady), .respValid(respValid),
        .respData(respData), .respReady(respReady));

    rio_remote_model #(.TocPtr(TOC)) i_rio_remote_model (.clk(clk),
        .rst(rst), .reqValid(reqValid), .reqData(reqData),
        .reqReady(reqReady), .respValid(respValid), .respData(respData),
        .respReady(respReady), .failMask(failMask), .delay(delay),
        .mute(mute), .nReq(nReq), .lastReq(lastReq));

    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task wr(logic [2:0] s, logic [2:0] c, logic [31:0] d);
        @(negedge clk);
        hostWr = 1'b1;
        hostSel = s;
        hostChan = c;
        hostWData = d;
        @(negedge clk);
        hostWr = 1'b0;
    endtask : wr

    task rd(logic [2:0] s, logic [2:0] c, output logic [31:0] v);
        @(negedge clk);
        hostSel = s;
        hostChan = c;
        repeat (2) @(negedge clk);
        v = hostRData;
    endtask : rd

    // bounded wait for the command register to clear
    task idle(int lim);
        int i;
        for (i = 0; i < lim && cmdBusy !== 1'b0; i++) @(negedge clk);
        total_checks++;
        if (i >= lim) begin
            mismatches++;
            $display("[ERR] cmdBusy expected 0 seen %b", cmdBusy);
            results();
        end
    endtask : idle

    task cmd(logic [15:0] v, int lim);
        base = nReq;
        wr(SEL_CMD, 3'h0, {16'h0, v});
        idle(lim);
    endtask : cmd

    task dat(logic [7:0] e);
        logic [31:0] v;
        rd(SEL_DATA, 3'h0, v);
        chk("data", {24'h0, e}, v);
    endtask : dat

    task t_start;
        cmd(16'h0800, 10);
        failMask = 8'h02;
        cmd(16'h0903, SC + 20);
        chk("reqs", 32'd2, 32'(nReq - base));
        chk("kind", 32'(REQ_START), 32'(lastReq.kind));
        dat(8'h02);
        failMask = 8'h00;
    endtask : t_start

    task t_cyclic;
        logic [31:0] v;
        chk("busy", 32'h0, {31'h0, cmdBusy});
        wr(SEL_IF0, 3'h0, 32'h00AB_CDEF);
        cmd(16'h1005, XC + 20);
        chk("reqs", 32'd1, 32'(nReq - base));
        chk("out", 32'h00AB_CDEF, lastReq.ifr[0]);
        dat(8'h04);
        rd(SEL_IF0, 3'h0, v);
        chk("if0", 32'hFF54_3210, v);
        rd(SEL_CS, 3'h0, v);
        chk("cs", 32'h1122_3344, v);
    endtask : t_cyclic

    task t_refuse;
        delay = 8'd30;
        base = nReq;
        wr(SEL_CMD, 3'h0, 32'h1001);
        wr(SEL_CMD, 3'h0, 32'h0901);
        idle(XC + 20);
        chk("reqs", 32'd1, 32'(nReq - base));
        chk("kind", 32'(REQ_XFER), 32'(lastReq.kind));
        wr(SEL_CMD, 3'h0, 32'h8901);
        chk("ignore", 32'h0, {31'h0, cmdBusy});
        wr(SEL_CMD, 3'h0, 32'h1001);
        wr(SEL_CMD, 3'h0, 32'h0800);
        idle(6);
        delay = 8'h00;
        cmd(16'h1001, XC + 20);
        dat(8'h01);
    endtask : t_refuse

    task t_setup;
        logic [31:0] v, w;
        logic [7:0] op;
        cmd(16'h0800, 10);
        cmd(16'h0F01, SC + 20);
        chk("kind", 32'(REQ_SETUP), 32'(lastReq.kind));
        dat(8'h00);
        rd(SEL_IF2, 3'h0, v);
        chk("toc", TOC, v);
        // every width of read and write, then one unknown opcode
        for (int i = 0; i < 9; i++) begin
            op = i < 4 ? 8'(8'h44 + i) : i < 8 ? 8'(8'h60 + i) : 8'h50;
            w = {op, 8'h00, 12'h001, i[3:0]};
            wr(SEL_IF0, 3'h0, 32'(i));
            wr(SEL_CS, 3'h0, w);
            cmd(16'h1001, XC + 20);
            dat(i < 8 ? 8'h00 : 8'h01);
            if (i < 8) chk("csout", w, lastReq.cs);
            if (i < 8) chk("ifout", 32'(i), lastReq.ifr[0]);
        end
    endtask : t_setup

    task t_timeout;
        // channel must be running, or the transfer fails locally
        cmd(16'h0901, SC + 20);
        mute = 1'b1;
        cmd(16'h1001, XC + 30);
        dat(8'h01);
        mute = 1'b0;
    endtask : t_timeout

    task t_buffer;
        cmd(16'h0800, 10);
        failMask = 8'h80;
        cmd(16'h09FF, SC + 40);
        chk("reqs", 32'd8, 32'(nReq - base));
        dat(8'h80);
        chk("stall", 32'h1, {31'h0, stalls > 0});
        failMask = 8'h00;
    endtask : t_buffer

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_start();
        t_cyclic();
        t_refuse();
        t_timeout();
        t_setup();
        t_buffer();
        results();
    end
endmodule : tb
